// ---- logic/cic_pkg.sv ----
// Purpose: constants for the cpu information clear register bank
// Assumes: 16-bit buffer memory words, one word per address
// Notes:   clear processing length is a time in ns, rounded up to whole clock cycles
`default_nettype none
package cic_pkg;
   localparam int          ADDR_W            = 12;
   localparam int          DATA_W            = 16;
   localparam int          CPU_TYPE_W        = 16;
   // buffer memory offsets
   localparam logic [11:0] ADDR_CLR_REQ      = 12'h080;
   localparam logic [11:0] ADDR_CH1_SEQ      = 12'h255;
   localparam logic [11:0] ADDR_NAK_CODE     = 12'h25a;
   localparam logic [11:0] ADDR_CH2_SEQ      = 12'h265;
   // values
   localparam logic [15:0] CLEAR_CODE        = 16'h4c43;
   localparam logic [15:0] CLEAR_DONE_VAL    = 16'h0000;
   localparam logic [15:0] SEQ_STATUS_RESET  = 16'h0000;
   localparam logic [15:0] NAK_CODE_RESET    = 16'h0000;
   localparam logic [15:0] READ_ZERO         = 16'h0000;
   // timing
   localparam int          CLEAR_TIME_NS     = 40;
   localparam int          CLK_PERIOD_NS     = 10;
   localparam int          CLEAR_CYCLES      = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  CLEAR_CNT_LAST    = 4'(CLEAR_CYCLES - 1);

   typedef enum logic [3:0] {
      CIC_IDLE = 4'b0001,
      CIC_HOLD = 4'b0010,
      CIC_RUN  = 4'b0100,
      CIC_DONE = 4'b1000
   } cic_state_e;
endpackage
`default_nettype wire

// ---- logic/cic_clr_if.sv ----
// Purpose: signals between the bank and the clear sequencer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse from the bank
`timescale 1ns/10ps
`default_nettype none
interface cic_clr_if;
   logic start;
   logic busy;
   logic done;
   logic run_entry;
   modport seq  (input start, output busy, output done, output run_entry);
   modport bank (output start, input busy, input done, input run_entry);
endinterface
`default_nettype wire

// ---- logic/cic_clear_seq.sv ----
// Purpose: sequencing of the cpu information clear
// Assumes: start pulses on a clear code write
// Notes:   a request during reinit is held until it ends
`timescale 1ns/10ps
`default_nettype none
module cic_clear_seq
   import cic_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // status from protocol engine
   input  wire logic reinit_instruction_busy,
   // bank side
   cic_clr_if.seq    clr
);
   cic_state_e st_q, st_d;
   logic [3:0] cnt_q, cnt_d;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         CIC_IDLE: begin
            if (clr.start) begin
               st_d  = reinit_instruction_busy ? CIC_HOLD : CIC_RUN;
               cnt_d = 4'h0;
            end
         end
         CIC_HOLD: begin
            if (!reinit_instruction_busy) begin
               st_d = CIC_RUN;
            end
         end
         CIC_RUN: begin
            if (cnt_q == CLEAR_CNT_LAST) begin
               st_d = CIC_DONE;
            end else begin
               cnt_d = cnt_q + 4'h1;
            end
         end
         CIC_DONE: begin
            st_d = CIC_IDLE;
         end
         default: begin
            st_d = CIC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_q  <= CIC_IDLE;
         cnt_q <= 4'h0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   assign clr.busy      = (st_q != CIC_IDLE);
   assign clr.done      = (st_q == CIC_DONE);
   assign clr.run_entry = (st_q != CIC_RUN) && (st_d == CIC_RUN);
endmodule
`default_nettype wire

// ---- logic/cic_cpu_info.sv ----
// Purpose: holds the access target cpu type
// Assumes: fetch answer comes on cpu_type_valid
// Notes:   one fetch request per empty store
`timescale 1ns/10ps
`default_nettype none
module cic_cpu_info
   import cic_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   // access and fetch
   input  wire logic                  cpu_access,
   input  wire logic                  cpu_type_valid,
   input  wire logic [CPU_TYPE_W-1:0] cpu_type_in,
   // discard sources
   input  wire logic                  discard,
   // state
   output logic                       fetch_req,
   output logic                       info_valid,
   output logic [CPU_TYPE_W-1:0]      info
);
   logic                  valid_q, valid_d;
   logic                  pend_q, pend_d;
   logic [CPU_TYPE_W-1:0] info_q, info_d;

   always_comb begin
      valid_d   = valid_q;
      pend_d    = pend_q;
      info_d    = info_q;
      fetch_req = 1'b0;
      if (discard) begin
         valid_d = 1'b0;
         pend_d  = 1'b0;
         info_d  = '0;
      end else if (pend_q && cpu_type_valid) begin
         valid_d = 1'b1;
         pend_d  = 1'b0;
         info_d  = cpu_type_in;
      end else if (cpu_access && !valid_q && !pend_q) begin
         pend_d    = 1'b1;
         fetch_req = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         valid_q <= 1'b0;
         pend_q  <= 1'b0;
         info_q  <= '0;
      end else begin
         valid_q <= valid_d;
         pend_q  <= pend_d;
         info_q  <= info_d;
      end
   end

   assign info_valid = valid_q;
   assign info       = info_q;
endmodule
`default_nettype wire

// ---- logic/cic_bank.sv ----
// Purpose: buffer memory words for cpu information clear and errors
// Assumes: host and external device ports are synchronous to clk_sys
// Notes:   unmapped words read zero and ignore writes
`timescale 1ns/10ps
`default_nettype none
module cic_bank
   import cic_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   // host cpu buffer memory port
   input  wire logic [ADDR_W-1:0]     hst_addr,
   input  wire logic                  hst_wr,
   input  wire logic                  hst_rd,
   input  wire logic [DATA_W-1:0]     hst_wdata,
   output logic [DATA_W-1:0]          hst_rdata_q,
   output logic                       hst_rvalid_q,
   // external device buffer memory port
   input  wire logic [ADDR_W-1:0]     ext_addr,
   input  wire logic                  ext_wr,
   input  wire logic                  ext_rd,
   input  wire logic [DATA_W-1:0]     ext_wdata,
   output logic [DATA_W-1:0]          ext_rdata_q,
   output logic                       ext_rvalid_q,
   // serial receive path
   input  wire logic                  rx_valid,
   input  wire logic [7:0]            rx_data,
   output logic                       rx_out_valid_q,
   output logic [7:0]                 rx_out_data_q,
   // protocol engine events
   input  wire logic                  nak_valid,
   input  wire logic [DATA_W-1:0]     nak_code,
   input  wire logic                  comm_error,
   input  wire logic                  seq1_valid,
   input  wire logic [DATA_W-1:0]     seq1_status,
   input  wire logic                  seq2_valid,
   input  wire logic [DATA_W-1:0]     seq2_status,
   input  wire logic                  reinit_instruction_busy,
   // host cpu information
   input  wire logic                  cpu_reset,
   input  wire logic                  cpu_access,
   input  wire logic                  cpu_type_valid,
   input  wire logic [CPU_TYPE_W-1:0] cpu_type_in,
   output logic                       cpu_fetch_req_q,
   output logic                       cpu_info_valid_q,
   output logic [CPU_TYPE_W-1:0]      cpu_info_q,
   // modem and indicator
   input  wire logic                  modem_attached,
   output logic                       modem_disconnect_q,
   output logic                       err_led_q,
   output logic                       clear_busy_q
);
   cic_clr_if clr ();

   logic [DATA_W-1:0]     clr_req_q, clr_req_d;
   logic [DATA_W-1:0]     seq1_q, seq1_d;
   logic [DATA_W-1:0]     seq2_q, seq2_d;
   logic [DATA_W-1:0]     nak_q, nak_d;
   logic [DATA_W-1:0]     hst_rdata_d, ext_rdata_d;
   logic                  err_led_d;
   logic                  fetch_req;
   logic                  info_valid;
   logic [CPU_TYPE_W-1:0] info;

   // address is a writable word for either side
   function automatic logic is_rw(input logic [ADDR_W-1:0] a);
      return (a == ADDR_CLR_REQ) || (a == ADDR_NAK_CODE);
   endfunction

   function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a,
                                                 input logic [DATA_W-1:0] c,
                                                 input logic [DATA_W-1:0] s1,
                                                 input logic [DATA_W-1:0] n,
                                                 input logic [DATA_W-1:0] s2);
      logic [DATA_W-1:0] r;
      r = READ_ZERO;
      if (a == ADDR_CLR_REQ) begin
         r = c;
      end else if (a == ADDR_CH1_SEQ) begin
         r = s1;
      end else if (a == ADDR_NAK_CODE) begin
         r = n;
      end else if (a == ADDR_CH2_SEQ) begin
         r = s2;
      end
      return r;
   endfunction

   logic hst_w_ok, ext_w_ok, hst_clr_w, ext_clr_w;
   logic start_pulse;

   assign hst_w_ok    = hst_wr && is_rw(hst_addr);
   assign ext_w_ok    = ext_wr && is_rw(ext_addr);
   assign hst_clr_w   = hst_w_ok && (hst_addr == ADDR_CLR_REQ);
   assign ext_clr_w   = ext_w_ok && (ext_addr == ADDR_CLR_REQ);
   assign start_pulse = !clr.busy &&
                        ((hst_clr_w && (hst_wdata == CLEAR_CODE)) ||
                         (ext_clr_w && (ext_wdata == CLEAR_CODE)));
   assign clr.start   = start_pulse;

   cic_clear_seq u_seq (
      .clk_sys                 (clk_sys),
      .nrst                    (nrst),
      .reinit_instruction_busy (reinit_instruction_busy),
      .clr                     (clr)
   );

   cic_cpu_info u_info (
      .clk_sys        (clk_sys),
      .nrst           (nrst),
      .cpu_access     (cpu_access),
      .cpu_type_valid (cpu_type_valid),
      .cpu_type_in    (cpu_type_in),
      .discard        (cpu_reset || clr.done),
      .fetch_req      (fetch_req),
      .info_valid     (info_valid),
      .info           (info)
   );

   // register words
   always_comb begin
      clr_req_d = clr_req_q;
      if (ext_clr_w) begin
         clr_req_d = ext_wdata;
      end
      if (hst_clr_w) begin
         clr_req_d = hst_wdata;
      end
      if (clr.busy && !start_pulse) begin
         clr_req_d = clr_req_q;
      end
      if (clr.done) begin
         clr_req_d = CLEAR_DONE_VAL;
      end

      seq1_d = seq1_valid ? seq1_status : seq1_q;
      seq2_d = seq2_valid ? seq2_status : seq2_q;
      if (clr.done) begin
         seq1_d = SEQ_STATUS_RESET;
         seq2_d = SEQ_STATUS_RESET;
      end

      nak_d = nak_q;
      if (ext_w_ok && (ext_addr == ADDR_NAK_CODE)) begin
         nak_d = ext_wdata;
      end
      if (hst_w_ok && (hst_addr == ADDR_NAK_CODE)) begin
         nak_d = hst_wdata;
      end
      if (nak_valid) begin
         nak_d = nak_code;
      end

      err_led_d = err_led_q || comm_error;

      hst_rdata_d = hst_rd ? rd_word(hst_addr, clr_req_q, seq1_q, nak_q, seq2_q)
                           : hst_rdata_q;
      ext_rdata_d = ext_rd ? rd_word(ext_addr, clr_req_q, seq1_q, nak_q, seq2_q)
                           : ext_rdata_q;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         clr_req_q          <= CLEAR_DONE_VAL;
         seq1_q             <= SEQ_STATUS_RESET;
         seq2_q             <= SEQ_STATUS_RESET;
         nak_q              <= NAK_CODE_RESET;
         err_led_q          <= 1'b0;
         hst_rdata_q        <= READ_ZERO;
         hst_rvalid_q       <= 1'b0;
         ext_rdata_q        <= READ_ZERO;
         ext_rvalid_q       <= 1'b0;
         rx_out_valid_q     <= 1'b0;
         rx_out_data_q      <= 8'h00;
         modem_disconnect_q <= 1'b0;
         clear_busy_q       <= 1'b0;
         cpu_fetch_req_q    <= 1'b0;
         cpu_info_valid_q   <= 1'b0;
         cpu_info_q         <= '0;
      end else begin
         clr_req_q          <= clr_req_d;
         seq1_q             <= seq1_d;
         seq2_q             <= seq2_d;
         nak_q              <= nak_d;
         err_led_q          <= err_led_d;
         hst_rdata_q        <= hst_rdata_d;
         hst_rvalid_q       <= hst_rd;
         ext_rdata_q        <= ext_rdata_d;
         ext_rvalid_q       <= ext_rd;
         // also drop in the last cycle that clear_busy_q still reports
         rx_out_valid_q     <= rx_valid && !clr.busy && !start_pulse && !clear_busy_q;
         rx_out_data_q      <= rx_data;
         modem_disconnect_q <= clr.run_entry && modem_attached;
         clear_busy_q       <= clr.busy || start_pulse;
         cpu_fetch_req_q    <= fetch_req;
         cpu_info_valid_q   <= info_valid;
         cpu_info_q         <= info;
      end
   end
endmodule
`default_nettype wire

// ---- dv/cic_bank_props.sv ----
// Purpose: assertions on the ports of the cpu information clear bank
// Assumes: one clock, nrst asynchronous and active low
// Notes:   bound to cic_bank below
`timescale 1ns/10ps
`default_nettype none
module cic_bank_props
   import cic_pkg::*;
(
   // clock and reset
   input wire logic              clk_sys,
   input wire logic              nrst,
   // host port
   input wire logic [ADDR_W-1:0] hst_addr,
   input wire logic              hst_wr,
   input wire logic              hst_rd,
   input wire logic [DATA_W-1:0] hst_wdata,
   input wire logic              hst_rvalid_q,
   // events and status
   input wire logic              rx_valid,
   input wire logic              rx_out_valid_q,
   input wire logic              comm_error,
   input wire logic              err_led_q,
   input wire logic              reinit_instruction_busy,
   input wire logic              clear_busy_q,
   input wire logic              modem_attached,
   input wire logic              modem_disconnect_q,
   input wire logic              cpu_access,
   input wire logic              cpu_fetch_req_q,
   input wire logic              cpu_info_valid_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_clr_req;
      hst_wr && hst_addr == ADDR_CLR_REQ && !clear_busy_q;
   endsequence
   sequence s_clr_end;
      ##[1:12] !clear_busy_q;
   endsequence
   AST_RD_ANSWER: assert property (hst_rd |=> hst_rvalid_q)
      else $error("host read not answered");
   AST_CLR_START: assert property ((s_clr_req ##0 hst_wdata == CLEAR_CODE) |=> clear_busy_q)
      else $error("clear code did not start a clear");
   AST_NO_START: assert property ((s_clr_req ##0 hst_wdata != CLEAR_CODE) |=> !clear_busy_q)
      else $error("other value started a clear");
   AST_CLR_DONE: assert property ($rose(clear_busy_q) && !reinit_instruction_busy |-> s_clr_end)
      else $error("clear did not finish in time");
   AST_HOLD_END: assert property ($fell(reinit_instruction_busy) && clear_busy_q |-> s_clr_end)
      else $error("held clear did not finish after reinit");
   AST_RX_DROP: assert property (rx_valid && clear_busy_q |=> !rx_out_valid_q)
      else $error("byte passed during clear");
   AST_LED: assert property ($rose(err_led_q) |-> $past(comm_error))
      else $error("error indicator lit without comm error");
   AST_MODEM: assert property ($rose(modem_disconnect_q) |-> modem_attached && clear_busy_q)
      else $error("modem cut outside a clear");
   AST_INFO_DROP: assert property ($fell(clear_busy_q) |-> !cpu_info_valid_q)
      else $error("cpu info kept after clear");
   AST_FETCH: assert property ($rose(cpu_fetch_req_q) |-> $past(cpu_access) && !$past(cpu_info_valid_q))
      else $error("fetch without access to empty store");
endmodule
bind cic_bank cic_bank_props u_props (.clk_sys, .nrst, .hst_addr, .hst_wr, .hst_rd, .hst_wdata,
   .hst_rvalid_q, .rx_valid, .rx_out_valid_q, .comm_error, .err_led_q, .reinit_instruction_busy,
   .clear_busy_q, .modem_attached, .modem_disconnect_q, .cpu_access, .cpu_fetch_req_q,
   .cpu_info_valid_q);
`default_nettype wire

// ---- dv/cic_host_cpu_model.sv ----
// Purpose: host cpu answering cpu type fetch requests
// Assumes: fetch request is a one-cycle pulse
// Notes:   type lines show the inverse value outside an answer
`timescale 1ns/10ps
`default_nettype none
module cic_host_cpu_model
   import cic_pkg::*;
#(
   parameter int                    DELAY    = 3,
   parameter logic [CPU_TYPE_W-1:0] CPU_TYPE = 16'h0a5c
)
(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   // fetch handshake
   input  wire logic                  fetch_req,
   output logic                       type_valid,
   output logic [CPU_TYPE_W-1:0]      type_out
);
   int cnt;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
      end else if (fetch_req) begin
         cnt <= DELAY;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   assign type_valid = (cnt == 1);
   assign type_out   = type_valid ? CPU_TYPE : ~CPU_TYPE;
endmodule
`default_nettype wire

// ---- dv/cic_bank_tb.sv ----
// Purpose: self-checking bench for the cpu information clear bank
// Assumes: inputs change at the falling edge
// Notes:   host cpu type value is arbitrary
`timescale 1ns/10ps
`default_nettype none
module cic_bank_tb;
   import cic_pkg::*;
   localparam logic [15:0] HOST_TYPE = 16'h0a5c;
   logic              clk_sys = 1'b0, nrst = 1'b0, hst_wr = 1'b0, hst_rd = 1'b0;
   logic              ext_wr = 1'b0, ext_rd = 1'b0, rx_valid = 1'b0, nak_valid = 1'b0;
   logic              comm_error = 1'b0, seq1_valid = 1'b0, seq2_valid = 1'b0;
   logic              reinit_instruction_busy = 1'b0, cpu_reset = 1'b0, cpu_access = 1'b0;
   logic              modem_attached = 1'b0, modem_seen = 1'b0, seen_v = 1'b0;
   logic [DATA_W-1:0] seen_q = 16'h0000;
   logic              hst_rvalid_q, ext_rvalid_q, rx_out_valid_q, cpu_fetch_req_q;
   logic              cpu_info_valid_q, modem_disconnect_q, err_led_q, clear_busy_q;
   logic              cpu_type_valid;
   logic [7:0]        rx_data = 8'h00, rx_out_data_q;
   logic [ADDR_W-1:0] hst_addr = 12'h000, ext_addr = 12'h000;
   logic [DATA_W-1:0] hst_wdata = 16'h0000, ext_wdata = 16'h0000, nak_code = 16'h0000;
   logic [DATA_W-1:0] seq1_status = 16'h0000, seq2_status = 16'h0000;
   logic [DATA_W-1:0] hst_rdata_q, ext_rdata_q, cpu_type_in, cpu_info_q;
   int                n_errors = 0, comparisons = 0, cycles = 0;
   cic_bank u_dut (.clk_sys, .nrst, .hst_addr, .hst_wr, .hst_rd, .hst_wdata, .hst_rdata_q,
      .hst_rvalid_q, .ext_addr, .ext_wr, .ext_rd, .ext_wdata, .ext_rdata_q, .ext_rvalid_q,
      .rx_valid, .rx_data, .rx_out_valid_q, .rx_out_data_q, .nak_valid, .nak_code, .comm_error,
      .seq1_valid, .seq1_status, .seq2_valid, .seq2_status, .reinit_instruction_busy,
      .cpu_reset, .cpu_access, .cpu_type_valid, .cpu_type_in, .cpu_fetch_req_q,
      .cpu_info_valid_q, .cpu_info_q, .modem_attached, .modem_disconnect_q, .err_led_q,
      .clear_busy_q);
   cic_host_cpu_model #(.DELAY(3), .CPU_TYPE(HOST_TYPE)) u_host (.clk_sys, .nrst,
      .fetch_req(cpu_fetch_req_q), .type_valid(cpu_type_valid), .type_out(cpu_type_in));
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (modem_disconnect_q === 1'b1) begin
         modem_seen <= 1'b1;
      end
      if (cycles == 5000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic close_out();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (exp !== got) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic e, input logic w, input logic [11:0] a, input logic [15:0] d);
      {ext_wr, ext_rd, hst_wr, hst_rd} = e ? {w, !w, 2'b00} : {2'b00, w, !w};
      {hst_addr, ext_addr, hst_wdata, ext_wdata} = {a, a, d, d};
      @(negedge clk_sys);
      // read answer stands for one cycle only: take it here
      seen_v = e ? ext_rvalid_q : hst_rvalid_q;
      seen_q = e ? ext_rdata_q : hst_rdata_q;
      {ext_wr, ext_rd, hst_wr, hst_rd} = 4'h0;
      @(negedge clk_sys);
   endtask
   task automatic rd(input logic e, input logic [11:0] a, input logic [15:0] exp);
      acc(e, 1'b0, a, 16'h0000);
      chk($sformatf("rvalid %h", a), 16'h0001, 16'(seen_v));
      chk($sformatf("word %h", a), exp, seen_q);
   endtask
   task automatic wait_for(ref logic s, input logic v);
      for (int i = 0; i < 40 && s !== v; i++) @(negedge clk_sys);
   endtask
   task automatic fetch();
      cpu_access = 1'b1;
      @(negedge clk_sys);
      cpu_access = 1'b0;
      wait_for(cpu_info_valid_q, 1'b1);
      chk("cpu_info", HOST_TYPE, cpu_info_q);
   endtask
   task automatic t_reset();
      rd(1'b0, ADDR_CLR_REQ, 16'h0000);
      rd(1'b1, ADDR_CH1_SEQ, 16'h0000);
      rd(1'b0, ADDR_NAK_CODE, 16'h0000);
      rd(1'b1, ADDR_CH2_SEQ, 16'h0000);
      rd(1'b0, 12'h123, 16'h0000);
   endtask
   task automatic t_info();
      fetch();
      cpu_access = 1'b1;
      @(negedge clk_sys);
      cpu_access = 1'b0;
      @(negedge clk_sys);
      chk("fetch_req", 16'h0000, 16'(cpu_fetch_req_q));
   endtask
   task automatic t_seq_nak();
      {seq1_valid, seq2_valid, nak_valid} = 3'b111;
      {seq1_status, seq2_status, nak_code} = {16'h1234, 16'h5678, 16'h7140};
      @(negedge clk_sys);
      {seq1_valid, seq2_valid, nak_valid} = 3'b000;
      acc(1'b0, 1'b1, ADDR_CH1_SEQ, 16'hffff);
      acc(1'b1, 1'b1, ADDR_CH2_SEQ, 16'hffff);
      rd(1'b1, ADDR_CH1_SEQ, 16'h1234);
      rd(1'b0, ADDR_CH2_SEQ, 16'h5678);
      rd(1'b1, ADDR_NAK_CODE, 16'h7140);
      chk("err_led", 16'h0000, 16'(err_led_q));
      acc(1'b0, 1'b1, ADDR_NAK_CODE, 16'h0000);
      rd(1'b0, ADDR_NAK_CODE, 16'h0000);
      comm_error = 1'b1;
      @(negedge clk_sys);
      comm_error = 1'b0;
      @(negedge clk_sys);
      chk("err_led", 16'h0001, 16'(err_led_q));
   endtask
   task automatic t_other();
      acc(1'b0, 1'b1, ADDR_CLR_REQ, 16'h4c44);
      chk("busy", 16'h0000, 16'(clear_busy_q));
      rd(1'b1, ADDR_CLR_REQ, 16'h4c44);
      chk("info_valid", 16'h0001, 16'(cpu_info_valid_q));
   endtask
   task automatic t_clear();
      modem_attached = 1'b1;
      acc(1'b0, 1'b1, ADDR_CLR_REQ, CLEAR_CODE);
      chk("busy", 16'h0001, 16'(clear_busy_q));
      {rx_valid, rx_data} = {1'b1, 8'h5a};
      @(negedge clk_sys);
      rx_valid = 1'b0;
      chk("rx_out_valid", 16'h0000, 16'(rx_out_valid_q));
      wait_for(clear_busy_q, 1'b0);
      rd(1'b0, ADDR_CLR_REQ, CLEAR_DONE_VAL);
      rd(1'b1, ADDR_CH1_SEQ, SEQ_STATUS_RESET);
      rd(1'b0, ADDR_CH2_SEQ, SEQ_STATUS_RESET);
      chk("info_valid", 16'h0000, 16'(cpu_info_valid_q));
      chk("modem_cut", 16'h0001, 16'(modem_seen));
      {rx_valid, rx_data} = {1'b1, 8'hc3};
      @(negedge clk_sys);
      rx_valid = 1'b0;
      chk("rx_out", 16'h01c3, {7'h00, rx_out_valid_q, rx_out_data_q});
   endtask
   task automatic t_hold();
      reinit_instruction_busy = 1'b1;
      acc(1'b0, 1'b1, ADDR_CLR_REQ, CLEAR_CODE);
      repeat (12) @(negedge clk_sys);
      chk("busy", 16'h0001, 16'(clear_busy_q));
      rd(1'b1, ADDR_CLR_REQ, CLEAR_CODE);
      reinit_instruction_busy = 1'b0;
      wait_for(clear_busy_q, 1'b0);
      rd(1'b0, ADDR_CLR_REQ, CLEAR_DONE_VAL);
   endtask
   task automatic t_cpu_reset();
      fetch();
      cpu_reset = 1'b1;
      @(negedge clk_sys);
      cpu_reset = 1'b0;
      wait_for(cpu_info_valid_q, 1'b0);
      chk("info_valid", 16'h0000, 16'(cpu_info_valid_q));
      fetch();
      nrst = 1'b0;
      repeat (2) @(negedge clk_sys);
      nrst = 1'b1;
      chk("info_valid", 16'h0000, 16'(cpu_info_valid_q));
   endtask
   initial begin
      repeat (20) @(negedge clk_sys);
      nrst = 1'b1;
      t_reset();
      t_info();
      t_seq_nak();
      t_other();
      t_clear();
      t_hold();
      t_cpu_reset();
      close_out();
   end
endmodule
`default_nettype wire
